// ==== verilog/diag_bus_edge_irq.sv ====
// Top of the diagnostic bus edge interrupt block with its register port.
`timescale 1ns/1ps
// Behaviour
// - Four channels, one byte slice each.
// - Flags read-only, cleared on register read unless their edge comes in that same cycle.
// - Chosen edge sets the channel flag.
// - Edge bit zero rising, one falling.
// - Bit pick selects one of eight.
// - Bus pick selects link0, link1, rf0, rf1.
// - Enabled channel interrupts on flag rise.
module diag_bus_edge_irq
    import diag_irq_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  clk_en,
    input  wire logic [addr_width-1:0] addr,
    input  wire logic [data_width-1:0] wdata,
    input  wire logic                  wr_strobe,
    input  wire logic                  rd_strobe,
    output logic      [data_width-1:0] rdata,
    input  wire logic [7:0]            link_probe_bus0,
    input  wire logic [7:0]            link_probe_bus1,
    input  wire logic [7:0]            rf_probe_bus0,
    input  wire logic [7:0]            rf_probe_bus1,
    output logic                       diag_irq
);
    import diag_irq_pkg::*;

    logic [num_channels-1:0] diag_edge_polarity;
    logic [num_channels-1:0] next_edge_polarity;
    logic [2:0]              diag_bit_pick      [num_channels];
    logic [2:0]              next_bit_pick      [num_channels];
    logic [1:0]              diag_bus_pick      [num_channels];
    logic [1:0]              next_bus_pick      [num_channels];
    logic [num_channels-1:0] diag_irq_enable;
    logic [num_channels-1:0] next_irq_enable;
    logic [num_channels-1:0] diag_event_flag;
    logic [num_channels-1:0] flag_rise;
    logic [data_width-1:0]   ctrl_view;
    logic [data_width-1:0]   next_rdata;
    logic                    next_irq;
    logic                    hit_ctrl;
    logic                    flag_clear;

    assign hit_ctrl   = (addr == ctrl_addr);
    assign flag_clear = rd_strobe & hit_ctrl;

    // ---------------------------------------------------------------
    // Channels
    // ---------------------------------------------------------------
    for (genvar ch = 0; ch < num_channels; ch++) begin : g_ch
        diag_edge_channel u_ch (
            .ref_clk            (ref_clk),
            .reset_n            (reset_n),
            .clk_en             (clk_en),
            .link_probe_bus0    (link_probe_bus0),
            .link_probe_bus1    (link_probe_bus1),
            .rf_probe_bus0      (rf_probe_bus0),
            .rf_probe_bus1      (rf_probe_bus1),
            .diag_bus_pick      (diag_bus_pick[ch]),
            .diag_bit_pick      (diag_bit_pick[ch]),
            .diag_edge_polarity (diag_edge_polarity[ch]),
            .flag_clear         (flag_clear),
            .diag_event_flag    (diag_event_flag[ch]),
            .flag_rise          (flag_rise[ch])
        );
    end

    // ---------------------------------------------------------------
    // Register file and interrupt
    // ---------------------------------------------------------------
    always_comb begin
        ctrl_view          = ctrl_reset;
        next_edge_polarity = diag_edge_polarity;
        next_bit_pick      = diag_bit_pick;
        next_bus_pick      = diag_bus_pick;
        next_irq_enable    = diag_irq_enable;
        for (int ch = 0; ch < num_channels; ch++) begin
            // Each channel owns one byte; channel 3 is the top one.
            ctrl_view[ch*slice_width+flag_pos] = diag_event_flag[ch];
            ctrl_view[ch*slice_width+edge_pos] = diag_edge_polarity[ch];
            ctrl_view[ch*slice_width+bit_pick_lsb +: bit_pick_w] =
                diag_bit_pick[ch];
            ctrl_view[ch*slice_width+bus_pick_lsb +: bus_pick_w] =
                diag_bus_pick[ch];
            ctrl_view[ch*slice_width+enable_pos] = diag_irq_enable[ch];
            // The flag bit is not writable, so writes skip it.
            if (wr_strobe && hit_ctrl) begin
                next_edge_polarity[ch] = wdata[ch*slice_width+edge_pos];
                next_bit_pick[ch] =
                    wdata[ch*slice_width+bit_pick_lsb +: bit_pick_w];
                next_bus_pick[ch] =
                    wdata[ch*slice_width+bus_pick_lsb +: bus_pick_w];
                next_irq_enable[ch] = wdata[ch*slice_width+enable_pos];
            end
        end
        // Unmapped reads return zero.
        if (rd_strobe && hit_ctrl) begin
            next_rdata = ctrl_view;
        end else begin
            next_rdata = '0;
        end
        // A one-cycle pulse per cycle with any enabled rise; a level would hide a second event.
        next_irq = |(flag_rise & diag_irq_enable);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            diag_edge_polarity <= '0;
            diag_irq_enable    <= '0;
            for (int ch = 0; ch < num_channels; ch++) begin
                diag_bit_pick[ch] <= '0;
                diag_bus_pick[ch] <= '0;
            end
            rdata    <= '0;
            diag_irq <= 1'b0;
        end else if (clk_en) begin
            diag_edge_polarity <= next_edge_polarity;
            diag_irq_enable    <= next_irq_enable;
            diag_bit_pick      <= next_bit_pick;
            diag_bus_pick      <= next_bus_pick;
            rdata              <= next_rdata;
            diag_irq           <= next_irq;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_flag_sticky;
        @(posedge ref_clk) disable iff (!reset_n)
        (clk_en && !flag_clear && diag_event_flag[0]) |=> diag_event_flag[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without a read");

    property p_irq_needs_enable;
        @(posedge ref_clk) disable iff (!reset_n)
        diag_irq |-> $past(diag_irq_enable) != '0;
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
        else $error("interrupt with no channel enabled");

    property p_irq_on_rise;
        @(posedge ref_clk) disable iff (!reset_n)
        (clk_en && |(flag_rise & diag_irq_enable)) |=> diag_irq;
    endproperty
    a_irq_on_rise: assert property (p_irq_on_rise)
        else $error("enabled flag rise gave no interrupt");

    property p_irq_source;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(diag_event_flag[1]) && $past(diag_irq_enable[1]) && $past(clk_en)
            |-> diag_irq;
    endproperty
    a_irq_source: assert property (p_irq_source)
        else $error("channel 1 rise missed interrupt");

    property p_read_flag_view;
        @(posedge ref_clk) disable iff (!reset_n)
        (clk_en && flag_clear) |=>
            rdata[flag_pos] == $past(diag_event_flag[0]);
    endproperty
    a_read_flag_view: assert property (p_read_flag_view)
        else $error("read data flag mismatch");

    property p_write_bus_pick;
        @(posedge ref_clk) disable iff (!reset_n)
        (clk_en && wr_strobe && hit_ctrl) |=>
            diag_bus_pick[3] == $past(wdata[26:25]);
    endproperty
    a_write_bus_pick: assert property (p_write_bus_pick)
        else $error("channel 3 bus pick not written");

    property p_write_bit_pick;
        @(posedge ref_clk) disable iff (!reset_n)
        (clk_en && wr_strobe && hit_ctrl) |=>
            diag_bit_pick[0] == $past(wdata[5:3]) &&
            diag_edge_polarity[0] == $past(wdata[6]);
    endproperty
    a_write_bit_pick: assert property (p_write_bit_pick)
        else $error("channel 0 fields not written");

    c_irq: cover property (@(posedge ref_clk) disable iff (!reset_n)
        diag_irq);
    c_clear: cover property (@(posedge ref_clk) disable iff (!reset_n)
        flag_clear && diag_event_flag != '0);
    c_all_flags: cover property (@(posedge ref_clk) disable iff (!reset_n)
        diag_event_flag == 4'hf);
endmodule

// ==== verilog/diag_irq_pkg.sv ====
// Package with register map, field layout and reset values.
package diag_irq_pkg;
    localparam int          data_width     = 32;
    localparam int          addr_width     = 32;
    localparam logic [31:0] ctrl_addr      = 32'h4000_0204;
    localparam logic [31:0] ctrl_reset     = 32'h0000_0000;
    localparam int          num_channels   = 4;
    localparam int          slice_width    = 8;
    localparam int          probe_width    = 8;
    localparam int          flag_pos       = 7;
    localparam int          edge_pos       = 6;
    localparam int          bit_pick_lsb   = 3;
    localparam int          bit_pick_w     = 3;
    localparam int          bus_pick_lsb   = 1;
    localparam int          bus_pick_w     = 2;
    localparam int          enable_pos     = 0;
    localparam logic [1:0]  bus_link0      = 2'h0;
    localparam logic [1:0]  bus_link1      = 2'h1;
    localparam logic [1:0]  bus_rf0        = 2'h2;
    localparam logic [1:0]  bus_rf1        = 2'h3;
    localparam logic        edge_rising    = 1'b0;
endpackage

// ==== verilog/diag_edge_channel.sv ====
// One diagnostic edge channel: bus pick, bit pick, edge detect, sticky flag.
`timescale 1ns/1ps
module diag_edge_channel
    import diag_irq_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic [7:0]       link_probe_bus0,
    input  wire logic [7:0]       link_probe_bus1,
    input  wire logic [7:0]       rf_probe_bus0,
    input  wire logic [7:0]       rf_probe_bus1,
    input  wire logic [1:0]       diag_bus_pick,
    input  wire logic [2:0]       diag_bit_pick,
    input  wire logic             diag_edge_polarity,
    input  wire logic             flag_clear,
    output logic                  diag_event_flag,
    output logic                  flag_rise
);
    logic [7:0] picked_bus;
    logic       watched;
    logic       watched_prev;
    logic       hit;
    logic       next_flag;

    // ---------------------------------------------------------------
    // Selection and edge detection
    // ---------------------------------------------------------------
    always_comb begin
        if (diag_bus_pick == bus_link0) begin
            picked_bus = link_probe_bus0;
        end else if (diag_bus_pick == bus_link1) begin
            picked_bus = link_probe_bus1;
        end else if (diag_bus_pick == bus_rf0) begin
            picked_bus = rf_probe_bus0;
        end else begin
            picked_bus = rf_probe_bus1;
        end
        watched = picked_bus[diag_bit_pick];
        if (diag_edge_polarity == edge_rising) begin
            hit = watched & ~watched_prev;
        end else begin
            hit = ~watched & watched_prev;
        end
        // An edge in the clearing cycle wins, so no event is lost.
        if (hit) begin
            next_flag = 1'b1;
        end else if (flag_clear) begin
            next_flag = 1'b0;
        end else begin
            next_flag = diag_event_flag;
        end
    end

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            watched_prev    <= 1'b0;
            diag_event_flag <= 1'b0;
        end else if (clk_en) begin
            watched_prev    <= watched;
            diag_event_flag <= next_flag;
        end
    end

    // Combinational rise of the flag, registered by the top.
    assign flag_rise = next_flag & ~diag_event_flag & clk_en;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    // Only an edge in the reading cycle may keep the flag, since set wins.
    property p_clear_on_read;
        @(posedge ref_clk) disable iff (!reset_n)
        (clk_en && flag_clear && !hit) |=> !diag_event_flag;
    endproperty
    a_clear_on_read: assert property (p_clear_on_read)
        else $error("flag not cleared by read");
endmodule

// ==== sim/probe_source.sv ====
// Model of the link-layer and radio diagnostic buses feeding the block.
`timescale 1ns/1ps
module probe_source (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       load,
    input  wire logic [1:0] load_sel,
    input  wire logic [7:0] load_val,
    output logic      [7:0] link_probe_bus0,
    output logic      [7:0] link_probe_bus1,
    output logic      [7:0] rf_probe_bus0,
    output logic      [7:0] rf_probe_bus1
);
    // ------------------------------------------------------------------
    // Bus registers
    // ------------------------------------------------------------------
    // The real sources are synchronous logic, so values change only just
    // after a clock edge; zero in reset keeps release free of edges.
    logic [7:0] probe [4];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            probe <= '{default: 8'h00};
        end else if (load) begin
            probe[load_sel] <= load_val;
        end
    end

    assign link_probe_bus0 = probe[0];
    assign link_probe_bus1 = probe[1];
    assign rf_probe_bus0   = probe[2];
    assign rf_probe_bus1   = probe[3];
endmodule

// ==== sim/tb_top.sv ====
// Self-checking testbench for the diagnostic bus edge interrupt block.
`timescale 1ns/1ps
`define check_eq(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
        end \
    end
module tb_top;
    import diag_irq_pkg::*;
    logic                  ref_clk = 1'b0;
    logic                  reset_n = 1'b0;
    logic [addr_width-1:0] addr = '0;
    logic [data_width-1:0] wdata = '0;
    logic                  wr_strobe = 1'b0;
    logic                  rd_strobe = 1'b0;
    logic [data_width-1:0] rdata;
    logic [7:0]            link_probe_bus0, link_probe_bus1;
    logic [7:0]            rf_probe_bus0, rf_probe_bus1;
    logic                  diag_irq;
    logic                  load = 1'b0;
    logic [1:0]            load_sel = 2'h0;
    logic [7:0]            load_val = 8'h00;
    logic [7:0]            bus_val [4] = '{default: 8'h00};
    logic [31:0]           exp_q [$];
    logic [31:0]           mask_q [$];
    logic [31:0]           mon_e, mon_m, cfg, flag;
    logic [7:0]            v;
    logic [2:0]            b;
    logic [1:0]            w;
    logic                  e, en, rd_d = 1'b0;
    logic                  clk_en = 1'b1;
    int                    c, fails = 0, samples_checked = 0;
    int                    irq_seen = 0, irq_exp = 0;
    integer                seed = 66701;

    always #2.5 ref_clk = ~ref_clk;

    diag_bus_edge_irq i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rdata(rdata),
        .link_probe_bus0(link_probe_bus0), .link_probe_bus1(link_probe_bus1),
        .rf_probe_bus0(rf_probe_bus0), .rf_probe_bus1(rf_probe_bus1),
        .diag_irq(diag_irq));

    probe_source i_probe (.ref_clk(ref_clk), .reset_n(reset_n), .load(load),
        .load_sel(load_sel), .load_val(load_val),
        .link_probe_bus0(link_probe_bus0), .link_probe_bus1(link_probe_bus1),
        .rf_probe_bus0(rf_probe_bus0), .rf_probe_bus1(rf_probe_bus1));

    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr_strobe <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_strobe <= 1'b0;
    endtask

    // Only bits set in m are compared, so flags of idle channels are free.
    task automatic reg_read(input logic [31:0] a, input logic [31:0] x,
                            input logic [31:0] m);
        exp_q.push_back(x);
        mask_q.push_back(m);
        @(posedge ref_clk);
        rd_strobe <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_strobe <= 1'b0;
    endtask

    task automatic set_bus(input logic [1:0] s, input logic [7:0] d);
        bus_val[s] = d;
        @(posedge ref_clk);
        load <= 1'b1;
        load_sel <= s;
        load_val <= d;
        @(posedge ref_clk);
        load <= 1'b0;
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rd_d) begin
            mon_m = mask_q.pop_front();
            mon_e = exp_q.pop_front();
            `check_eq(rdata & mon_m, mon_e & mon_m)
        end
        if (diag_irq === 1'b1) irq_seen++;
        rd_d = rd_strobe;
    end

    initial begin
        #100_000;
        fails++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_read(ctrl_addr, ctrl_reset, 32'hFFFF_FFFF);
        reg_write(ctrl_addr, 32'hFFFF_FFFF);
        reg_read(ctrl_addr, 32'h7F7F_7F7F, 32'hFFFF_FFFF);
        reg_write(ctrl_addr + 32'h0000_0004, 32'h0000_0000);
        reg_read(ctrl_addr + 32'h0000_0004, 32'h0000_0000, 32'hFFFF_FFFF);
        reg_read(ctrl_addr, 32'h7F7F_7F7F, 32'hFFFF_FFFF);
        set_bus(2'h3, 8'h80);
        set_bus(2'h3, 8'h00);
        irq_exp++;
        reg_read(ctrl_addr, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        reg_read(ctrl_addr, 32'h7F7F_7F7F, 32'hFFFF_FFFF);
        `check_eq(irq_seen, irq_exp)
        for (int i = 0; i < 16; i++) begin
            c = i % 4;
            w = 2'(i / 4);
            b = 3'($random(seed));
            e = 1'($random(seed));
            en = (i % 3) != 0;
            cfg = 32'({1'b0, e, b, w, 1'b0}) << (8 * c);
            flag = 32'h0000_0080 << (8 * c);
            v = 8'($random(seed));
            v[b] = e;
            // Write first, so the last channel is masked before the bus moves.
            reg_write(ctrl_addr, cfg);
            set_bus(w, v);
            repeat (2) @(posedge ref_clk);
            reg_read(ctrl_addr, cfg, 32'h7F7F_7F7F);
            cfg[8 * c] = en;
            reg_write(ctrl_addr, cfg);
            set_bus(w, bus_val[w] ^ ~(8'h01 << b));
            set_bus(w + 2'h1, 8'($random(seed)));
            reg_read(ctrl_addr, cfg, 32'h7F7F_7F7F | flag);
            set_bus(w, bus_val[w] ^ (8'h01 << b));
            irq_exp += int'(en);
            reg_read(ctrl_addr, cfg | flag, 32'h7F7F_7F7F | flag);
            reg_read(ctrl_addr, cfg, 32'h7F7F_7F7F | flag);
            set_bus(w, bus_val[w] ^ (8'h01 << b));
            reg_read(ctrl_addr, cfg, 32'h7F7F_7F7F | flag);
            `check_eq(irq_seen, irq_exp)
        end
        // A pulse that comes and goes while frozen must leave no flag.
        clk_en <= 1'b0;
        set_bus(w, bus_val[w] ^ (8'h01 << b));
        set_bus(w, bus_val[w] ^ (8'h01 << b));
        clk_en <= 1'b1;
        reg_read(ctrl_addr, cfg, 32'h7F7F_7F7F | flag);
        `check_eq(irq_seen, irq_exp)
        final_report();
    end
endmodule
